// >>> rtl/nvc_ctrl.sv
// nvm controller register file and command sequencer
// Notes on behaviour
// RL1: nonzero command field write starts an operation
// RL2: code one writes page, two erases page
// RL3: code three erases then writes, four clears buffer
// RL4: five erases all unless preserve fuse; six eeprom
// RL5: code seven writes fuse, debug port only
// RL6: host writes key before command, else ignored
// RL7: boot lock makes boot reads and fetches zero
// RL8: boot lock writable from boot code; reset clears
// RL9: new boot lock acts after leaving boot section
// RL10: app write protect blocks application writes
// RL11: app protect set only; reset clears it
// RL12: write error reports failed last operation
// RL13: write error reflects only latest operation
// RL14: eeprom busy high while eeprom works
// RL15: flash busy high while flash works
// RL16: enable bit enables eeprom ready interrupt
// RL17: eeprom ready interrupt is level, requests immediately
// RL18: software enables interrupt after command, disables in handler
// RL19: flag cleared by writing one; the code clears it only while eeprom busy, when idle the set wins
// RL20: data register bytes; value for fuse write
// RL21: address register holds last updated location
// RL22: all registers reset to zero
// RL23: page buffer cleared after write or erase
// RL24: buffer clear sets ones, holds cpu seven
// RL25: flash ops halt cpu, eeprom ops do not
// RL26: host checks busy bits before new command
// RL27: undefined bits read zero, ignore writes
`timescale 1ns/1ps
module nvc_ctrl (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // access context
  input  wire logic        key_ok,
  input  wire logic        from_debug_port,
  input  wire logic        exec_in_boot,
  input  wire logic        eeprom_preserve_fuse,
  // page buffer side
  input  wire logic        pb_wr_valid,
  input  wire logic [15:0] pb_wr_addr,
  input  wire logic        pb_mixed_sections,
  output logic             pb_clear,
  // memory array side
  output logic             mem_start,
  output logic [2:0]       mem_cmd,
  output logic             mem_to_eeprom,
  output logic             mem_keep_eeprom,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_data,
  input  wire logic        mem_done,
  input  wire logic        mem_fail,
  // cpu read path gating
  input  wire logic        cpu_rd_in_boot,
  input  wire logic [15:0] cpu_rd_raw,
  output logic      [15:0] cpu_rd_data,
  output logic             cpu_halt,
  // eeprom ready request
  output logic             eeprom_ready_irq
);
`include "nvc_consts.svh"

  logic [1:0] rst_sync;
  logic       rst_n;

  // reset asserts at once, releases through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] b);
    sel_hit = (a == b);
  endfunction : sel_hit

  // register state
  logic [2:0]           command_control;
  logic                 app_write_protect;
  logic                 boot_lock_a;
  logic                 boot_lock_live;
  logic                 write_error;
  logic                 interrupt_enable;
  logic                 interrupt_flag;
  logic [15:0]          fuse_write_value;
  logic [15:0]          last_update_address;
  nvc_pkg::nvc_state_t  state;
  nvc_pkg::nvc_state_t  next_state;
  logic [2:0]           pbc_cnt;
  logic                 in_boot_q;

  // bus decode
  // a held request is taken every second cycle: ack masks it
  wire       bus_req  = cyc_i & stb_i & ~ack_o;
  wire       bus_wr   = bus_req & we_i & sel_i[0];
  wire [3:0] idx      = adr_i[5:2];
  wire [7:0] wbyte    = dat_i[7:0];
  wire       wr_cmd   = bus_wr & sel_hit(idx, `NVC_IDX_CMD);
  wire       wr_prot  = bus_wr & sel_hit(idx, `NVC_IDX_PROT);
  wire       wr_inten = bus_wr & sel_hit(idx, `NVC_IDX_INTEN);
  wire       wr_flag  = bus_wr & sel_hit(idx, `NVC_IDX_INTFLAG);
  wire       wr_dlo   = bus_wr & sel_hit(idx, `NVC_IDX_DATA_LO);
  wire       wr_dhi   = bus_wr & sel_hit(idx, `NVC_IDX_DATA_HI);
  wire       wr_alo   = bus_wr & sel_hit(idx, `NVC_IDX_ADDR_LO);
  wire       wr_ahi   = bus_wr & sel_hit(idx, `NVC_IDX_ADDR_HI);

  // busy views of the sequencer state
  wire idle        = (state == nvc_pkg::NVC_ST_IDLE);
  wire flash_busy  = (state == nvc_pkg::NVC_ST_FLASH) |
                     (state == nvc_pkg::NVC_ST_PBC);
  wire eeprom_busy = (state == nvc_pkg::NVC_ST_EE);

  // target memory and protection of the addressed location
  wire tgt_ee   = (last_update_address >= `NVC_EE_BASE) &
                  (last_update_address <  `NVC_EE_END);
  wire tgt_boot = (last_update_address <  `NVC_BOOT_END);
  wire tgt_app  = ~tgt_boot & (last_update_address < `NVC_APP_END);

  // command acceptance
  // debug port needs no key; cpu needs the key this cycle
  // refused codes record an error and leave the field alone
  wire [2:0] wcode  = wbyte[`NVC_CMD_MSB:0];
  wire cmd_key_ok   = key_ok | from_debug_port;                  // RL6
  wire cmd_take     = wr_cmd & cmd_key_ok & idle &
                      (wcode != nvc_pkg::NVC_CMD_NONE);          // RL1
  wire is_page_op   = (wcode == nvc_pkg::NVC_CMD_WRITE) |
                      (wcode == nvc_pkg::NVC_CMD_ERASE) |
                      (wcode == nvc_pkg::NVC_CMD_ERWR);
  wire is_pbc       = (wcode == nvc_pkg::NVC_CMD_PBCLR);
  wire is_fuse      = (wcode == nvc_pkg::NVC_CMD_FUSE);
  wire is_ee_only   = (wcode == nvc_pkg::NVC_CMD_EEPROM_ERASE_CMD);
  wire fuse_refused = is_fuse & ~from_debug_port;                // RL5
  wire prot_hit     = is_page_op & ~tgt_ee &
                      ((tgt_app & app_write_protect) |           // RL10
                       (tgt_boot & boot_lock_live));
  wire op_error     = fuse_refused | prot_hit |
                      (is_page_op & pb_mixed_sections);          // RL12
  wire launch       = cmd_take & ~op_error & ~is_pbc;
  wire launch_ee    = is_ee_only | (is_page_op & tgt_ee);        // RL2 RL3 RL4
  wire op_end       = mem_done & (flash_busy | eeprom_busy) &
                      (state != nvc_pkg::NVC_ST_PBC);
  wire pbc_end      = (state == nvc_pkg::NVC_ST_PBC) &
                      (pbc_cnt == `NVC_PBC_CYCLES);

  // one operation at a time; array done returns to idle
  always_comb begin
    next_state = state;
    unique case (state)
      nvc_pkg::NVC_ST_IDLE: begin
        if (cmd_take & is_pbc)
          next_state = nvc_pkg::NVC_ST_PBC;                      // RL3
        else if (launch & launch_ee)
          next_state = nvc_pkg::NVC_ST_EE;                       // RL25
        else if (launch)
          next_state = nvc_pkg::NVC_ST_FLASH;                    // RL25
      end
      nvc_pkg::NVC_ST_PBC: begin
        if (pbc_end) next_state = nvc_pkg::NVC_ST_IDLE;          // RL24
      end
      nvc_pkg::NVC_ST_FLASH,
      nvc_pkg::NVC_ST_EE: begin
        if (mem_done) next_state = nvc_pkg::NVC_ST_IDLE;
      end
      default: next_state = nvc_pkg::NVC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= nvc_pkg::NVC_ST_IDLE;
      pbc_cnt <= 3'h0;
    end else begin
      state   <= next_state;
      // restarts at one, so the clear holds exactly seven cycles
      if (state == nvc_pkg::NVC_ST_PBC) begin
        pbc_cnt <= pbc_cnt + 3'h1;
      end else begin
        pbc_cnt <= 3'h1;
      end
    end
  end

  // command field, write error
  // each accepted command or finished op rewrites the error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      command_control <= 3'h0;                                   // RL22
      write_error     <= 1'b0;
    end else begin
      if (cmd_take & ~op_error)
        command_control <= wcode;                                // RL1
      else if (op_end | pbc_end)
        command_control <= 3'h0;
      if (cmd_take)
        write_error <= op_error;                                 // RL13
      else if (op_end)
        write_error <= mem_fail;                                 // RL12
    end
  end

  // protection bits
  // lock bits are sticky until reset
  wire boot_lock_wr = wr_prot & wbyte[`NVC_BIT_BOOT_LOCK_A] & exec_in_boot;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      app_write_protect <= 1'b0;
      boot_lock_a       <= 1'b0;
      boot_lock_live    <= 1'b0;
      in_boot_q         <= 1'b0;
    end else begin
      in_boot_q <= exec_in_boot;
      if (wr_prot & wbyte[`NVC_BIT_APP_WRITE_PROTECT]) begin
        app_write_protect <= 1'b1;                               // RL11
      end
      if (boot_lock_wr) begin
        boot_lock_a <= 1'b1;                                     // RL8
      end
      if (boot_lock_a & in_boot_q & ~exec_in_boot) begin
        boot_lock_live <= 1'b1;                                  // RL9
      end else if (boot_lock_a & ~exec_in_boot) begin
        boot_lock_live <= 1'b1;                                  // RL9
      end
    end
  end

  // locked boot section reads and fetches return zero
  assign cpu_rd_data = (boot_lock_live & cpu_rd_in_boot) ?
                       16'h0000 : cpu_rd_raw;                    // RL7

  // interrupt enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable <= 1'b0;                                  // RL22
    end else if (wr_inten) begin
      interrupt_enable <= wbyte[`NVC_BIT_EERDY];                 // RL16
    end
  end

  // ready flag; set wins over clear, so it clears only while busy
  wire flag_clr = wr_flag & wbyte[`NVC_BIT_EERDY];               // RL19
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_flag <= 1'b0;
    end else if (~eeprom_busy) begin
      interrupt_flag <= 1'b1;                                    // RL17
    end else if (flag_clr) begin
      interrupt_flag <= 1'b0;                                    // RL19
    end
  end
  assign eeprom_ready_irq = interrupt_enable & interrupt_flag;   // RL17

  // data register; the debug port loads it before a fuse write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuse_write_value <= `NVC_RST_WORD;                         // RL22
    end else begin
      if (wr_dlo) begin
        fuse_write_value[7:0] <= wbyte;                          // RL20
      end
      if (wr_dhi) begin
        fuse_write_value[15:8] <= wbyte;                         // RL20
      end
    end
  end

  // address register; a page buffer write wins over a bus write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_update_address <= `NVC_RST_WORD;                      // RL22
    end else if (pb_wr_valid) begin
      last_update_address <= pb_wr_addr;                         // RL21
    end else begin
      if (wr_alo) begin
        last_update_address[7:0] <= wbyte;
      end
      if (wr_ahi) begin
        last_update_address[15:8] <= wbyte;
      end
    end
  end

  // buffer refill with ones after a page op or on request
  wire prev_page_cmd = (command_control == nvc_pkg::NVC_CMD_WRITE) |
                       (command_control == nvc_pkg::NVC_CMD_ERASE) |
                       (command_control == nvc_pkg::NVC_CMD_ERWR);
  wire pbc_go        = cmd_take & ~op_error & is_pbc;            // RL24
  wire page_clear    = op_end & prev_page_cmd;                   // RL23

  // memory side outputs; operands latched at launch only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_start       <= 1'b0;
      mem_cmd         <= 3'h0;
      mem_to_eeprom   <= 1'b0;
      mem_keep_eeprom <= 1'b0;
      mem_addr        <= `NVC_RST_WORD;
      mem_data        <= `NVC_RST_WORD;
    end else begin
      mem_start <= launch;                                       // RL2
      if (launch) begin
        mem_cmd         <= wcode;
        mem_to_eeprom   <= launch_ee;
        mem_keep_eeprom <= eeprom_preserve_fuse;                 // RL4
        mem_addr        <= last_update_address;                  // RL21
        mem_data        <= fuse_write_value;                     // RL20
      end
    end
  end

  // one-cycle pulse to the page buffer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pb_clear <= 1'b0;
    end else begin
      pb_clear <= pbc_go | page_clear;
    end
  end

  assign cpu_halt = flash_busy;                                  // RL25

  // read mux; undefined bits and addresses read zero
  // each register byte built once, unused bits tied low
  wire [7:0] rd_cmd    = {5'h00, command_control};
  wire [7:0] rd_prot   = {6'h00, boot_lock_a, app_write_protect};
  wire [7:0] rd_status = {5'h00, write_error, eeprom_busy, flash_busy};
  wire [7:0] rd_inten  = {7'h00, interrupt_enable};
  wire [7:0] rd_flag   = {7'h00, interrupt_flag};
  wire [7:0] rd_dlo    = fuse_write_value[7:0];
  wire [7:0] rd_dhi    = fuse_write_value[15:8];
  wire [7:0] rd_alo    = last_update_address[7:0];
  wire [7:0] rd_ahi    = last_update_address[15:8];

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;                                             // RL27
    unique case (idx)
      `NVC_IDX_CMD:     rd_byte = rd_cmd;
      `NVC_IDX_PROT:    rd_byte = rd_prot;
      `NVC_IDX_STATUS:  rd_byte = rd_status;                     // RL14 RL15
      `NVC_IDX_INTEN:   rd_byte = rd_inten;
      `NVC_IDX_INTFLAG: rd_byte = rd_flag;
      `NVC_IDX_DATA_LO: rd_byte = rd_dlo;
      `NVC_IDX_DATA_HI: rd_byte = rd_dhi;
      `NVC_IDX_ADDR_LO: rd_byte = rd_alo;
      `NVC_IDX_ADDR_HI: rd_byte = rd_ahi;
      default:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      // ack and read data stand for one cycle
      ack_o <= bus_req;
      dat_o <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
endmodule : nvc_ctrl

// >>> rtl/nvc_consts.svh
// offsets, field positions, reset values and timing for the nvm controller
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH

// register indexes; the byte address on the bus is four times the index
`define NVC_IDX_CMD      4'h0
`define NVC_IDX_PROT     4'h1
`define NVC_IDX_STATUS   4'h2
`define NVC_IDX_INTEN    4'h3
`define NVC_IDX_INTFLAG  4'h4
`define NVC_IDX_DATA_LO  4'h6
`define NVC_IDX_DATA_HI  4'h7
`define NVC_IDX_ADDR_LO  4'h8
`define NVC_IDX_ADDR_HI  4'h9

// field positions
`define NVC_CMD_MSB      2
`define NVC_BIT_APP_WRITE_PROTECT    0
`define NVC_BIT_BOOT_LOCK_A 1
`define NVC_BIT_FLASH_BUSY    0
`define NVC_BIT_EEPROM_BUSY   1
`define NVC_BIT_WRERR    2
`define NVC_BIT_EERDY    0

// reset values
`define NVC_RST_BYTE     8'h00
`define NVC_RST_WORD     16'h0000

// memory map of the arrays, plain defaults
`define NVC_BOOT_END     16'h0200
`define NVC_APP_END      16'h1000
`define NVC_EE_BASE      16'h1400
`define NVC_EE_END       16'h1500

// page buffer clear holds the cpu this many cycles
`define NVC_PBC_CYCLES   3'h7
`endif

// >>> rtl/nvc_pkg.sv
// types of the nvm controller
package nvc_pkg;
  typedef enum logic [2:0] {
    NVC_CMD_NONE   = 3'h0,
    NVC_CMD_WRITE  = 3'h1,
    NVC_CMD_ERASE  = 3'h2,
    NVC_CMD_ERWR   = 3'h3,
    NVC_CMD_PBCLR  = 3'h4,
    NVC_CMD_CHIPER = 3'h5,
    NVC_CMD_EEPROM_ERASE_CMD   = 3'h6,
    NVC_CMD_FUSE   = 3'h7
  } nvc_cmd_t;

  typedef enum logic [3:0] {
    NVC_ST_IDLE  = 4'b0001,
    NVC_ST_PBC   = 4'b0010,
    NVC_ST_FLASH = 4'b0100,
    NVC_ST_EE    = 4'b1000
  } nvc_state_t;
endpackage : nvc_pkg

// >>> sim/nvc_props.sv
// port assertions for the nvm controller
`timescale 1ns/1ps
module nvc_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // context and array side
  input wire logic        key_ok,
  input wire logic        from_debug_port,
  input wire logic        pb_clear,
  input wire logic        mem_start,
  input wire logic [2:0]  mem_cmd,
  input wire logic        mem_to_eeprom,
  input wire logic        mem_done,
  input wire logic        cpu_halt,
  input wire logic        eeprom_ready_irq
);
  logic busy_q;
  wire  take = cyc_i && stb_i && we_i && !ack_o;
  wire  cmd_wr = take && adr_i[5:2] == 4'h0;
  wire  idle = !busy_q && !cpu_halt;
  wire  pg_cmd = mem_cmd inside {3'h1, 3'h2, 3'h3};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // array operation outstanding
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      busy_q <= 1'b0;
    else if (mem_start || mem_done)
      busy_q <= mem_start;
  sequence s_go(c);
    cmd_wr && dat_i[2:0] == c && idle && (key_ok || from_debug_port);
  endsequence
  sequence s_hold7;
    pb_clear && cpu_halt ##1 cpu_halt [*6] ##1 !cpu_halt;
  endsequence
  start_cause_a: assert property (mem_start |->
    $past(cmd_wr && dat_i[2:0] != 3'h0)) else $error("start without cmd");
  code_zero_a: assert property (cmd_wr && dat_i[2:0] == 3'h0
    |=> !mem_start && !pb_clear) else $error("code zero acted");
  no_key_a: assert property (cmd_wr && !key_ok && !from_debug_port
    |=> !mem_start) else $error("keyless command started");
  fuse_cpu_a: assert property (cmd_wr && dat_i[2:0] == 3'h7
    && !from_debug_port |=> !mem_start) else $error("cpu fuse started");
  cmd_copy_a: assert property (mem_start |->
    mem_cmd == $past(dat_i[2:0])) else $error("wrong array command");
  pbc_hold_a: assert property (s_go(3'h4) |=> s_hold7)
    else $error("buffer clear hold wrong");
  flash_halt_a: assert property (mem_start && pg_cmd
    |-> cpu_halt == !mem_to_eeprom) else $error("halt wrong");
  buf_auto_a: assert property (mem_done && busy_q && pg_cmd
    |=> pb_clear) else $error("no buffer clear after op");
  irq_on_a: assert property (take && adr_i[5:2] == 4'h3
    && dat_i[0] && !busy_q |-> ##[1:2] eeprom_ready_irq)
    else $error("ready request missing");
endmodule : nvc_props

bind nvc_ctrl nvc_props u_props (.*);

// >>> sim/nvc_array_model.sv
// array stand-in: answers each start after a set delay
`timescale 1ns/1ps
module nvc_array_model (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // bench controls
  input wire logic [7:0] dly,
  input wire logic       fail_req,
  // array handshake
  input wire logic       mem_start,
  output logic           mem_done,
  output logic           mem_fail
);
  logic [7:0] cnt;
  logic       run;
  logic       fail_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run      <= 1'b0;
      cnt      <= 8'h00;
      mem_done <= 1'b0;
      mem_fail <= 1'b0;
      fail_q   <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      // not sampled outside done, so shown wrong
      mem_fail <= ~fail_q;
      if (mem_start) begin
        run    <= 1'b1;
        cnt    <= dly;
        fail_q <= fail_req;
      end else if (run && cnt == 8'h00) begin
        run      <= 1'b0;
        mem_done <= 1'b1;
        mem_fail <= fail_q;
      end else if (run)
        cnt <= cnt - 8'h01;
    end
  end
endmodule : nvc_array_model

// >>> sim/testbench.sv
// self-checking bench for the nvm controller
`timescale 1ns/1ps
module testbench;
  logic        clk_sys, rst_b, cyc_i, stb_i, we_i, key_ok;
  logic        from_debug_port, exec_in_boot, eeprom_preserve_fuse;
  logic        pb_wr_valid, pb_mixed_sections, cpu_rd_in_boot, fail_req;
  logic        ack_o, pb_clear, mem_start, mem_to_eeprom, mem_keep_eeprom;
  logic        mem_done, mem_fail, cpu_halt, eeprom_ready_irq;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [2:0]  mem_cmd;
  logic [7:0]  dly;
  logic [31:0] dat_i, dat_o, s;
  logic [15:0] pb_wr_addr, mem_addr, mem_data, cpu_rd_raw, cpu_rd_data;
  int          n_errors, n_compared, n_clr, cycles, k;
  nvc_ctrl u_dut (.*);
  nvc_array_model u_mem (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_clr += (pb_clear === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(string nm, logic e, logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1
  task automatic bus(logic w, logic [3:0] ix, logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_sys); while (ack_o !== 1'b1);
    s = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(logic [3:0] ix, logic [7:0] d);
    bus(1'b1, ix, d);
  endtask : wr
  task automatic rdck(string nm, logic [3:0] ix, logic [31:0] e);
    bus(1'b0, ix, 8'h00);
    chk(nm, e, s);
  endtask : rdck
  task automatic settle();
    repeat (100) begin
      bus(1'b0, 4'h2, 8'h00);
      if (s[1:0] === 2'b00) return;
    end
    chk("idle", 32'h0, s);
  endtask : settle
  task automatic pbw(logic [15:0] a);
    pb_wr_valid <= 1'b1;
    pb_wr_addr  <= a;
    @(posedge clk_sys);
    pb_wr_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : pbw
  task automatic t_reset();
    for (int i = 0; i < 10; i++)
      rdck("reset", 4'(i), (i == 4) ? 32'h1 : 32'h0);
    wr(4'h5, 8'hFF);
    rdck("hole", 4'h5, 32'h0);
    wr(4'h6, 8'h5A);
    wr(4'h7, 8'hC3);
    rdck("data hi", 4'h7, 32'hC3);
    pbw(16'h0456);
    rdck("addr lo", 4'h8, 32'h56);
    rdck("addr hi", 4'h9, 32'h04);
    $display("done reset and registers");
  endtask : t_reset
  task automatic t_cmds();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    foreach (c[i]) begin
      fail_req <= (c[i] == 3'h2);
      k = n_clr;
      wr(4'h0, {5'h00, c[i]});
      chk("array cmd", {29'h0, c[i]}, {29'h0, mem_cmd});
      if (c[i] == 3'h5)
        chk1("keep", 1'b1, mem_keep_eeprom);
      rdck("busy", 4'h2, (c[i] == 3'h6) ? 32'h2 : 32'h1);
      settle();
      rdck("error", 4'h2, (c[i] == 3'h2) ? 32'h4 : 32'h0);
      if (c[i] < 3'h4)
        chk("cleared", 32'(k + 1), 32'(n_clr));
    end
    fail_req <= 1'b0;
    $display("done commands");
  endtask : t_cmds
  task automatic t_ee();
    dly <= 8'd60;
    wr(4'h3, 8'h01);
    chk1("irq", 1'b1, eeprom_ready_irq);
    pbw(16'h1410);
    wr(4'h0, 8'h01);
    chk1("to eeprom", 1'b1, mem_to_eeprom);
    chk("mem addr", 32'h1410, {16'h0, mem_addr});
    rdck("ee busy", 4'h2, 32'h2);
    wr(4'h4, 8'h00);
    rdck("flag", 4'h4, 32'h1);
    wr(4'h4, 8'h01);
    chk1("irq", 1'b0, eeprom_ready_irq);
    settle();
    rdck("flag", 4'h4, 32'h1);
    wr(4'h3, 8'h00);
    chk1("irq", 1'b0, eeprom_ready_irq);
    k = n_clr;
    wr(4'h0, 8'h04);
    chk1("halt", 1'b1, cpu_halt);
    repeat (7) @(posedge clk_sys);
    chk1("halt", 1'b0, cpu_halt);
    chk("cleared", 32'(k + 1), 32'(n_clr));
    $display("done eeprom and buffer clear");
  endtask : t_ee
  task automatic t_refuse();
    key_ok <= 1'b0;
    wr(4'h0, 8'h01);
    rdck("keyless", 4'h2, 32'h0);
    key_ok <= 1'b1;
    wr(4'h0, 8'h07);
    settle();
    rdck("cpu fuse", 4'h2, 32'h4);
    from_debug_port <= 1'b1;
    wr(4'h0, 8'h07);
    chk("fuse value", 32'hC35A, {16'h0, mem_data});
    settle();
    rdck("port fuse", 4'h2, 32'h0);
    from_debug_port <= 1'b0;
    pb_mixed_sections <= 1'b1;
    wr(4'h0, 8'h01);
    settle();
    rdck("mixed", 4'h2, 32'h4);
    pb_mixed_sections <= 1'b0;
    $display("done refusals");
  endtask : t_refuse
  task automatic t_protect();
    wr(4'h1, 8'h01);
    wr(4'h1, 8'h00);
    rdck("app lock", 4'h1, 32'h1);
    pbw(16'h0400);
    wr(4'h0, 8'h01);
    settle();
    rdck("app write", 4'h2, 32'h4);
    wr(4'h1, 8'h02);
    rdck("boot lock", 4'h1, 32'h1);
    exec_in_boot <= 1'b1;
    cpu_rd_in_boot <= 1'b1;
    cpu_rd_raw <= 16'hABCD;
    wr(4'h1, 8'h02);
    rdck("boot lock", 4'h1, 32'h3);
    chk("boot read", 32'hABCD, {16'h0, cpu_rd_data});
    exec_in_boot <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("boot read", 32'h0, {16'h0, cpu_rd_data});
    $display("done protection");
  endtask : t_protect
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {rst_b, cyc_i, stb_i, we_i, from_debug_port, exec_in_boot} = '0;
    {pb_wr_valid, pb_mixed_sections, cpu_rd_in_boot, fail_req} = '0;
    {adr_i, dat_i, pb_wr_addr, cpu_rd_raw} = '0;
    {key_ok, eeprom_preserve_fuse} = 2'b11;
    sel_i = 4'h1;
    dly = 8'd20;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_cmds();
    t_ee();
    t_refuse();
    t_protect();
    give_verdict();
  end
endmodule : testbench
